// >>> verilog/sgc_top.sv
`timescale 1ns/1ps
module sgc_top (
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic        SI,
  input  wire logic [5:0]  PARALLEL_CHANNEL_INPUT,
  input  wire logic        PWM_OVERRIDE_SELECT,
  input  wire logic        PWM_INPUT_FIRST_PAIR,
  input  wire logic        PWM_INPUT_SECOND_PAIR,
  input  wire logic [5:0]  DRAIN_MONITOR_ABOVE,
  input  wire logic [5:0]  DRAIN_MONITOR_BELOW,
  output logic      [5:0]  GATE_DRIVE_OUTPUT,
  output logic             SO_OUT,
  output logic             SO_OE,
  output logic      [5:0]  FAULT_STATUS
);
  // =====================================================
  // pin synchronisation
  logic [sgc_pkg::SY_W-1:0] pins_raw;
  logic [sgc_pkg::SY_W-1:0] pins_s;

  assign pins_raw = {DRAIN_MONITOR_BELOW,
                     DRAIN_MONITOR_ABOVE,
                     PARALLEL_CHANNEL_INPUT,
                     PWM_INPUT_SECOND_PAIR,
                     PWM_INPUT_FIRST_PAIR,
                     PWM_OVERRIDE_SELECT,
                     SI,
                     SCK,
                     CS_N};

  // every input pin but clock and reset, drain flags included, enters core clock here
  sgc_sync #(
    .W       (sgc_pkg::SY_W),
    .RST_VAL (sgc_pkg::SY_RST)
  ) u_sync (
    .clk  (CORE_CLK),
    .srst (SRST),
    .d    (pins_raw),
    .q    (pins_s)
  );

  wire       cs_s  = pins_s[sgc_pkg::SY_CS];
  wire       sck_s = pins_s[sgc_pkg::SY_SCK];
  wire       si_s  = pins_s[sgc_pkg::SY_SI];
  wire       sel_s = pins_s[sgc_pkg::SY_SEL];
  wire       pa_s  = pins_s[sgc_pkg::SY_PA];
  wire       pb_s  = pins_s[sgc_pkg::SY_PB];
  wire [5:0] par_s = pins_s[sgc_pkg::SY_PAR +: sgc_pkg::NUM_CH];
  wire [5:0] abv_s = pins_s[sgc_pkg::SY_ABV +: sgc_pkg::NUM_CH];
  wire [5:0] blw_s = pins_s[sgc_pkg::SY_BLW +: sgc_pkg::NUM_CH];

  // =====================================================
  // serial state
  logic                      sck_d;
  logic                      cs_d;
  logic [sgc_pkg::BCNT_W-1:0] bit_cnt;
  logic [15:0]               rx;
  logic [5:0]                spi_ctrl;
  logic [5:0]                fault_reg;
  logic [5:0]                live_fault;
  logic [5:0]                oc_flag;
  logic [5:0]                ol_flag;
  logic [5:0]                gate_q;

  // edges seen one stage past the synchroniser; sck must stay
  // well below a quarter of the core rate for this to hold
  wire sck_rise = sgc_pkg::sgc_rise(sck_d, sck_s);
  wire sck_fall = sgc_pkg::sgc_rise(sck_s, sck_d);
  wire cs_fall  = sgc_pkg::sgc_rise(cs_s, cs_d);
  wire cs_rise  = sgc_pkg::sgc_rise(cs_d, cs_s);

  wire shift_in  = sck_rise & ~cs_s;
  wire shift_out = sck_fall & ~cs_s;

  wire [sgc_pkg::BCNT_W-1:0] next_bit_cnt =
    cs_fall ? '0
    : (shift_in && bit_cnt != sgc_pkg::CNT_MAX)
      ? sgc_pkg::BCNT_W'(bit_cnt + 5'h01)
      : bit_cnt;

  // msb first into the low end
  wire [15:0] next_rx = shift_in ? {rx[14:0], si_s} : rx;

  // only whole 8 or 16 bit frames load control
  wire frame_ok = (bit_cnt == sgc_pkg::CNT_SHORT)
                | (bit_cnt == sgc_pkg::CNT_LONG);
  wire [5:0] next_ctrl = (cs_rise && frame_ok) ? rx[5:0] : spi_ctrl;

  // capture on select, follow when idle
  wire       fault_open = cs_s | cs_fall;
  wire [5:0] next_fault = fault_open ? live_fault : fault_reg;

  // =====================================================
  // echo inversion
  // first byte of a frame carries the channel fault positions and the
  // override flag; later bits go back unchanged
  wire       first_byte = (bit_cnt != '0)
                        & (bit_cnt <= sgc_pkg::CNT_SHORT);
  wire [2:0] echo_pos   = 3'(sgc_pkg::BYTE_TOP - bit_cnt[3:0]);
  wire       pos_is_ch  = echo_pos <= sgc_pkg::CH_TOP;
  wire       pos_is_flg = echo_pos == sgc_pkg::FLAG_POS;
  // faulted channel or active override inverts
  wire       echo_inv   = first_byte
                        & ((pos_is_ch & fault_reg[echo_pos])
                        |  (pos_is_flg & sel_s));
  wire       next_so    = shift_out ? (rx[0] ^ echo_inv) : SO_OUT;

  // =====================================================
  // serial registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sck_d     <= 1'b0;
      cs_d      <= 1'b1;
      bit_cnt   <= '0;
      rx        <= sgc_pkg::RX_RST;
      spi_ctrl  <= sgc_pkg::CTRL_RST;
      fault_reg <= '0;
      SO_OUT    <= 1'b0;
      SO_OE     <= 1'b0;
    end else begin
      sck_d     <= sck_s;
      cs_d      <= cs_s;
      bit_cnt   <= next_bit_cnt;
      rx        <= next_rx;
      spi_ctrl  <= next_ctrl;
      fault_reg <= next_fault;
      SO_OUT    <= next_so;
      SO_OE     <= ~cs_s;
    end
  end

  // =====================================================
  // gate command selection
  // serial OR parallel
  wire [5:0] cmd_norm = spi_ctrl | par_s;
  // pwm pairs, 2 and 3 stay parallel
  wire [5:0] cmd_ovr  = {pb_s, pb_s, par_s[3], par_s[2], pa_s, pa_s};
  // pwm ignored when override is low
  wire [5:0] cmd      = sel_s ? cmd_ovr : cmd_norm;

  // =====================================================
  // channels
  for (genvar i = 0; i < sgc_pkg::NUM_CH; i++) begin : g_ch
    sgc_chan u_chan (
      .clk   (CORE_CLK),
      .srst  (SRST),
      .cmd   (cmd[i]),
      .above (abv_s[i]),
      .below (blw_s[i]),
      .gate  (gate_q[i]),
      .oc    (oc_flag[i]),
      .ol    (ol_flag[i])
    );
  end

  // one bit per channel for either fault
  assign live_fault        = oc_flag | ol_flag;
  assign GATE_DRIVE_OUTPUT = gate_q;
  assign FAULT_STATUS      = fault_reg;

  // =====================================================
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_select;
    cs_fall;
  endsequence

  sequence s_selected_hold;
    !cs_s && !cs_fall;
  endsequence

  sequence s_frame_close;
    cs_rise && frame_ok;
  endsequence

  sequence s_first_echo;
    shift_out && bit_cnt == 5'h01;
  endsequence

  sequence s_idle_bus;
    cs_s;
  endsequence

  AST_FAULT_CAPTURE: assert property (
    s_select |=> fault_reg == $past(live_fault))
    else $error("faults not captured on select");

  AST_FAULT_FROZEN: assert property (
    s_selected_hold |=> $stable(fault_reg))
    else $error("fault register moved during transfer");

  AST_FAULT_FOLLOW: assert property (
    cs_s |=> fault_reg == $past(live_fault))
    else $error("fault register not following live faults");

  AST_SO_RELEASE: assert property (
    cs_s |=> !SO_OE)
    else $error("serial output driven while deselected");

  AST_SO_DRIVE: assert property (
    !cs_s ##1 !cs_s |-> SO_OE)
    else $error("serial output idle while selected");

  AST_SHIFT_IN: assert property (
    shift_in |=> rx[0] == $past(si_s)
              && (bit_cnt != $past(bit_cnt) || $past(bit_cnt) == 5'h1F))
    else $error("bit not shifted in");

  AST_CTRL_LOAD: assert property (
    s_frame_close |=> spi_ctrl == $past(rx[5:0]))
    else $error("control byte not loaded");

  AST_FLAG_ECHO: assert property (
    s_first_echo |=> SO_OUT == ($past(rx[0]) ^ $past(sel_s)))
    else $error("override flag echo wrong");

  AST_NORMAL_OR: assert property (
    !sel_s && cmd_norm[2] ##1 !oc_flag[2] |-> GATE_DRIVE_OUTPUT[2])
    else $error("normal command did not turn gate on");

  AST_PWM_FIRST: assert property (
    sel_s && pa_s ##1 !oc_flag[1] |-> GATE_DRIVE_OUTPUT[1])
    else $error("first pwm not followed");

  AST_PWM_MASK: assert property (
    sel_s && !pb_s |=> !GATE_DRIVE_OUTPUT[4] && !GATE_DRIVE_OUTPUT[5])
    else $error("serial or parallel leaked under override");

  AST_PAR_KEEP: assert property (
    sel_s && !par_s[3] |=> !GATE_DRIVE_OUTPUT[3])
    else $error("channel 3 not on its own input");

  AST_PWM_IGNORED: assert property (
    !sel_s && !cmd_norm[4] |=> !GATE_DRIVE_OUTPUT[4])
    else $error("pwm reached gate without override");

  AST_SO_HOLD: assert property (
    !shift_out |=> $stable(SO_OUT))
    else $error("serial output moved off a falling edge");

  AST_SO_QUIET: assert property (
    s_idle_bus |=> $stable(SO_OUT))
    else $error("serial output moved while deselected");

  AST_ECHO_PLAIN: assert property (
    shift_out && !first_byte |=> SO_OUT == $past(rx[0]))
    else $error("late bit not echoed as received");

  AST_CNT_CLEAR: assert property (
    s_select |=> bit_cnt == 5'h00)
    else $error("bit count not cleared on select");

  AST_OE_ON_SELECT: assert property (
    s_select |=> SO_OE)
    else $error("serial output not driven after select");

  AST_IDLE_STILL: assert property (
    s_idle_bus |=> $stable(rx) && $stable(bit_cnt))
    else $error("shift while deselected");

  AST_CTRL_HOLD: assert property (
    !(cs_rise && frame_ok) |=> $stable(spi_ctrl))
    else $error("control changed outside a whole frame");

  AST_PWM_SECOND: assert property (
    sel_s && pb_s ##1 !oc_flag[5] |-> GATE_DRIVE_OUTPUT[5])
    else $error("second pwm not followed");

  AST_PWM_MASK_LOW: assert property (
    sel_s && !pa_s |=> !GATE_DRIVE_OUTPUT[0] && !GATE_DRIVE_OUTPUT[1])
    else $error("low pair not masked under override");

  AST_PAR_ON: assert property (
    sel_s && par_s[2] ##1 !oc_flag[2] |-> GATE_DRIVE_OUTPUT[2])
    else $error("channel 2 not on its own input");

  AST_PWM_DONT_CARE: assert property (
    !sel_s && !spi_ctrl[5] && !par_s[5] |=> !GATE_DRIVE_OUTPUT[5])
    else $error("pwm drove a gate without override");

  AST_NORMAL_SPI: assert property (
    !sel_s && spi_ctrl[3] ##1 !oc_flag[3] |-> GATE_DRIVE_OUTPUT[3])
    else $error("serial bit did not turn gate on");

  AST_NORMAL_PAR: assert property (
    !sel_s && par_s[1] ##1 !oc_flag[1] |-> GATE_DRIVE_OUTPUT[1])
    else $error("parallel input did not turn gate on");

  AST_FAULT_BIT: assert property (
    cs_s && (oc_flag[0] || ol_flag[0]) |=> FAULT_STATUS[0])
    else $error("channel fault not shown");

  AST_POR_LOW: assert property (
    @(posedge CORE_CLK) disable iff (1'b0)
    SRST |=> GATE_DRIVE_OUTPUT == sgc_pkg::GATE_RST)
    else $error("gate not low after reset");
endmodule

// >>> verilog/sgc_pkg.sv
// Operation
// - chip select is active low and frames every serial transfer
// - while selected, each clock pulse shifts one bit in and one out
// - deselect releases the serial output and ends the transfer
// - selecting captures all fault bits, frozen for the whole transfer
// - while deselected the fault register follows live faults
// - an undriven chip select reads high, inactive
// - normal gate command is serial control bit OR parallel input
// - parallel inputs turn gates on when high, undriven read low
// - override ignores serial and parallel control of channels 0,1,4,5
// - override: channels 0,1 follow first pwm, 4,5 follow second pwm
// - override: channels 2 and 3 keep their own parallel inputs
// - without override both pwm inputs are ignored
// - undriven override select reads high, undriven pwm inputs read low
// - gate output high turns the transistor on, low turns it off
// - power-on reset forces every gate output low
// - over-current drives the gate in a low duty cycle pattern
// - over-current flagged when commanded on and drain above reference
// - open load flagged only when off and drain below reference
// - one fault bit per channel, for over-current or open load
// - output echoes input, faulted channel bits and override flag inverted
// - 8 or 16 bit frames, msb first, sample rise, shift fall
// - control bits 0 to 5 turn channels on; bits 6, 7 held low
// - duty pattern alternates sense on and refresh off until cleared
package sgc_pkg;
  // =====================================================
  // sizes
  localparam int NUM_CH = 6;
  localparam int CNT_W  = 12;
  localparam int BCNT_W = 5;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS       = 20;
  localparam int SHORT_SENSE_ON_NS   = 20000;
  localparam int REFRESH_OFF_NS      = 80000;
  localparam int OPEN_LOAD_QUAL_NS   = 40000;
  localparam int ON_CYC  = (SHORT_SENSE_ON_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int REF_CYC = (REFRESH_OFF_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int OL_CYC  = (OPEN_LOAD_QUAL_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] ON_LAST  = CNT_W'(ON_CYC - 1);
  localparam logic [CNT_W-1:0] REF_LAST = CNT_W'(REF_CYC - 1);
  localparam logic [CNT_W-1:0] OL_LAST  = CNT_W'(OL_CYC - 1);
  // =====================================================
  // serial frame
  localparam logic [BCNT_W-1:0] CNT_SHORT = 5'h08;
  localparam logic [BCNT_W-1:0] CNT_LONG  = 5'h10;
  localparam logic [BCNT_W-1:0] CNT_MAX   = 5'h1F;
  localparam logic [3:0]        BYTE_TOP  = 4'h8;
  localparam logic [2:0]        FLAG_POS  = 3'h7;
  localparam logic [2:0]        CH_TOP    = 3'h5;
  // =====================================================
  // synchroniser vector layout and idle levels
  localparam int SY_CS  = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SI  = 2;
  localparam int SY_SEL = 3;
  localparam int SY_PA  = 4;
  localparam int SY_PB  = 5;
  localparam int SY_PAR = 6;
  localparam int SY_ABV = 12;
  localparam int SY_BLW = 18;
  localparam int SY_W   = 24;
  localparam logic [SY_W-1:0] SY_RST = 24'h000009;
  // =====================================================
  // reset values
  localparam logic [NUM_CH-1:0] GATE_RST = 6'h00;
  localparam logic [NUM_CH-1:0] CTRL_RST = 6'h00;
  localparam logic [15:0]       RX_RST   = 16'h0000;
  // =====================================================
  // channel states
  typedef enum logic [2:0] {
    ST_NORM    = 3'h1,
    ST_REFRESH = 3'h2,
    ST_SENSE   = 3'h4
  } sgc_chan_st_t;

  function automatic logic sgc_rise(input logic prev, input logic cur);
    return cur & ~prev;
  endfunction
endpackage

// >>> verilog/sgc_sync.sv
`timescale 1ns/1ps
module sgc_sync #(
  parameter int                 W       = 1,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // =====================================================
  // two stages, the first read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> verilog/sgc_chan.sv
`timescale 1ns/1ps
module sgc_chan (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic cmd,
  input  wire logic above,
  input  wire logic below,
  output logic      gate,
  output logic      oc,
  output logic      ol
);
  sgc_pkg::sgc_chan_st_t          st;
  sgc_pkg::sgc_chan_st_t          next_st;
  logic [sgc_pkg::CNT_W-1:0]      cnt;
  logic [sgc_pkg::CNT_W-1:0]      next_cnt;
  logic [sgc_pkg::CNT_W-1:0]      ol_cnt;
  logic [sgc_pkg::CNT_W-1:0]      next_ol_cnt;
  logic                           next_oc;
  logic                           next_gate;
  logic                           next_ol;

  wire short_seen = cmd & above;
  wire open_seen  = ~cmd & below;
  wire ol_full    = (ol_cnt == sgc_pkg::OL_LAST);

  // =====================================================
  // duty cycle sequencer
  // sense and refresh
  always_comb begin
    next_st  = st;
    next_cnt = sgc_pkg::CNT_W'(cnt + 12'h001);
    next_oc  = oc;
    unique case (st)
      sgc_pkg::ST_NORM: begin
        if (!short_seen) begin
          next_cnt = '0;
        end else if (cnt == sgc_pkg::ON_LAST) begin
          next_st  = sgc_pkg::ST_REFRESH;
          next_cnt = '0;
          next_oc  = 1'b1;
        end
      end
      sgc_pkg::ST_REFRESH: begin
        if (!cmd) begin
          next_st  = sgc_pkg::ST_NORM;
          next_cnt = '0;
          next_oc  = 1'b0;
        end else if (cnt == sgc_pkg::REF_LAST) begin
          next_st  = sgc_pkg::ST_SENSE;
          next_cnt = '0;
        end
      end
      sgc_pkg::ST_SENSE: begin
        if (!cmd) begin
          next_st  = sgc_pkg::ST_NORM;
          next_cnt = '0;
          next_oc  = 1'b0;
        end else if (cnt == sgc_pkg::ON_LAST) begin
          next_cnt = '0;
          next_st  = above ? sgc_pkg::ST_REFRESH : sgc_pkg::ST_NORM;
          next_oc  = above;
        end
      end
      default: begin
        next_st  = sgc_pkg::ST_NORM;
        next_cnt = '0;
        next_oc  = 1'b0;
      end
    endcase
  end

  assign next_gate = (next_st == sgc_pkg::ST_NORM) ? cmd
                   : (next_st == sgc_pkg::ST_SENSE);
  assign next_ol_cnt = !open_seen ? '0
                     : ol_full ? ol_cnt
                     : sgc_pkg::CNT_W'(ol_cnt + 12'h001);
  assign next_ol     = open_seen & ol_full;

  // =====================================================
  // state registers
  // reset drops gate
  always_ff @(posedge clk) begin
    if (srst) begin
      st     <= sgc_pkg::ST_NORM;
      cnt    <= '0;
      oc     <= 1'b0;
      ol     <= 1'b0;
      ol_cnt <= '0;
      gate   <= 1'b0;
    end else begin
      st     <= next_st;
      cnt    <= next_cnt;
      oc     <= next_oc;
      ol     <= next_ol;
      ol_cnt <= next_ol_cnt;
      gate   <= next_gate;
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_SHORT_FLAG: assert property (
    st == sgc_pkg::ST_NORM && short_seen && cnt == sgc_pkg::ON_LAST
    |=> oc && !gate) else $error("short not flagged");
  AST_DUTY_OFF: assert property (
    $rose(oc) |-> !gate [*8]) else $error("gate on during refresh");
  AST_REFRESH_END: assert property (
    st == sgc_pkg::ST_REFRESH && cmd && cnt == sgc_pkg::REF_LAST
    |=> st == sgc_pkg::ST_SENSE && gate) else $error("no sense pulse");
  AST_OPEN_OFF: assert property (
    $rose(ol) |-> !$past(cmd)) else $error("open load while on");
endmodule

// >>> testbench/sgc_spi_master.sv
`timescale 1ns/1ps
// =====================================================
// serial master model, sck is 8 core cycles per period
module sgc_spi_master (
  input  wire logic clk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  logic so_wire;

  assign so_wire = so_oe ? so_out : 1'h1;

  initial begin
    cs_n = 1'h1;
    sck  = 1'h0;
    si   = 1'h0;
  end

  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // =====================================================
  // frame
  // select low frames it, msb first, sck low
  task automatic xfer(input  logic [15:0] d,
                      input  int          n,
                      output logic [15:0] echo);
    echo = 16'h0000;
    sck  = 1'h0;
    cs_n = 1'h0;
    half();
    for (int k = n - 1; k >= 0; k--) begin
      si = d[k];
      half();
      sck = 1'h1;
      half();
      // echo lags half a bit, so sample at the next fall
      if (k != n - 1) begin
        echo = {echo[14:0], so_wire};
      end
      sck = 1'h0;
    end
    half();
    half();
    echo = {echo[14:0], so_wire};
    cs_n = 1'h1;
    // released line must not keep showing the last bit
    si = ~si;
    // deselect must stand long enough to be seen between frames
    half();
  endtask
endmodule

// >>> testbench/six_channel_gate_control_test.sv
`timescale 1ns/1ps
module six_channel_gate_control_test;
  logic        core_clk;
  logic        srst;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        ovr;
  logic        pwm_a;
  logic        pwm_b;
  logic [5:0]  par;
  logic [5:0]  above;
  logic [5:0]  below;
  logic [5:0]  gate;
  logic        so_out;
  logic        so_oe;
  logic [5:0]  fault;
  logic [5:0]  ctrl;
  logic [15:0] echo;
  logic [15:0] d;
  int          n;
  int          cnt;
  int          num_errors;
  int          check_count;

  always #10 core_clk = ~core_clk;

  sgc_top u_dut (
    .CORE_CLK              (core_clk),
    .SRST                  (srst),
    .CS_N                  (cs_n),
    .SCK                   (sck),
    .SI                    (si),
    .PARALLEL_CHANNEL_INPUT(par),
    .PWM_OVERRIDE_SELECT   (ovr),
    .PWM_INPUT_FIRST_PAIR  (pwm_a),
    .PWM_INPUT_SECOND_PAIR (pwm_b),
    .DRAIN_MONITOR_ABOVE   (above),
    .DRAIN_MONITOR_BELOW   (below),
    .GATE_DRIVE_OUTPUT     (gate),
    .SO_OUT                (so_out),
    .SO_OE                 (so_oe),
    .FAULT_STATUS          (fault)
  );

  sgc_spi_master u_master (
    .clk   (core_clk),
    .so_out(so_out),
    .so_oe (so_oe),
    .cs_n  (cs_n),
    .sck   (sck),
    .si    (si)
  );

  // =====================================================
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({15'h0000, got}, {15'h0000, exp});
  endtask

  function automatic logic [15:0] exp_echo(input logic [15:0] dv,
                                           input int          nb,
                                           input logic [5:0]  flt,
                                           input logic        ov);
    return dv ^ ({8'h00, ov, 1'h0, flt} << (nb - 8));
  endfunction

  function automatic logic [5:0] exp_gate(input logic [5:0] c,
                                          input logic [5:0] p,
                                          input logic       ov,
                                          input logic       a,
                                          input logic       b);
    return ov ? {b, b, p[3:2], a, a} : (c | p);
  endfunction

  task automatic send(input logic [15:0] dv, input int nb,
                      input logic [5:0] flt, input logic ov);
    logic [15:0] mask;
    mask = (nb == 16) ? 16'hFFFF : 16'h00FF;
    u_master.xfer(dv, nb, echo);
    chk_vec(echo & mask, exp_echo(dv, nb, flt, ov));
  endtask

  // bounded wait, running out ends the run
  task automatic wait_fault(input int ch, input logic v, input int lim);
    int i;
    i = 0;
    while (fault[ch] !== v && i < lim) begin
      cyc(1);
      i++;
    end
    chk_bit(fault[ch], v);
    if (fault[ch] !== v) begin
      conclude();
    end
  endtask

  // =====================================================
  // sequence
  initial begin
    core_clk    = 1'h0;
    srst        = 1'h1;
    ovr         = 1'h1;
    pwm_a       = 1'h0;
    pwm_b       = 1'h0;
    par         = 6'h00;
    above       = 6'h00;
    below       = 6'h00;
    ctrl        = 6'h00;
    num_errors  = 0;
    check_count = 0;
    void'($urandom(48));
    cyc(8);
    chk_vec(16'(gate), 16'h0000);
    chk_bit(so_oe, 1'h0);
    srst = 1'h0;
    ovr  = 1'h0;
    cyc(6);
    // random control bytes, bits 7 and 6 low
    for (int i = 0; i < 12; i++) begin
      n     = ($urandom % 2) ? 16 : 8;
      ctrl  = 6'($urandom);
      par   = 6'($urandom);
      pwm_a = 1'($urandom);
      pwm_b = 1'($urandom);
      d     = {8'($urandom), 2'h0, ctrl};
      if (n == 8) begin
        d[15:8] = 8'h00;
      end
      send(d, n, 6'h00, 1'h0);
      cyc(8);
      chk_vec(16'(gate), 16'(exp_gate(ctrl, par, 1'h0, pwm_a, pwm_b)));
      chk_bit(so_oe, 1'h0);
    end
    // odd length frame must leave control alone
    u_master.xfer(16'h001F, 5, echo);
    cyc(8);
    chk_vec(16'(gate), 16'(exp_gate(ctrl, par, 1'h0, pwm_a, pwm_b)));
    ovr = 1'h1;
    for (int i = 0; i < 8; i++) begin
      par   = 6'($urandom);
      pwm_a = 1'($urandom);
      pwm_b = 1'($urandom);
      cyc(5);
      chk_vec(16'(gate), 16'(exp_gate(ctrl, par, 1'h1, pwm_a, pwm_b)));
    end
    send(16'h0000, 8, 6'h00, 1'h1);
    ovr   = 1'h0;
    par   = 6'h00;
    pwm_a = 1'h1;
    pwm_b = 1'h1;
    ctrl  = 6'h00;
    send(16'h0000, 8, 6'h00, 1'h0);
    cyc(8);
    chk_vec(16'(gate), 16'h0000);
    // open load on an idle channel, then frozen over a frame
    below = 6'h08;
    wait_fault(3, 1'h1, 2200);
    fork
      send(16'h0008, 8, 6'h08, 1'h0);
      begin
        cyc(20);
        below = 6'h00;
        cyc(20);
        chk_vec(16'(fault), 16'h0008);
        chk_bit(so_oe, 1'h1);
      end
    join
    cyc(8);
    chk_vec(16'(fault), 16'h0000);
    below = 6'h08;
    cyc(2200);
    chk_vec(16'(fault), 16'h0000);
    below = 6'h00;
    send(16'h0000, 8, 6'h00, 1'h0);
    // over-current on a parallel-driven channel
    par   = 6'h01;
    above = 6'h01;
    wait_fault(0, 1'h1, 1300);
    cnt = 0;
    for (int i = 0; i < 5000; i++) begin
      cyc(1);
      if (gate[0] === 1'h1) begin
        cnt++;
      end
    end
    chk_bit(cnt >= 990 && cnt <= 1010, 1'h1);
    above = 6'h00;
    wait_fault(0, 1'h0, 6200);
    cyc(2);
    chk_bit(gate[0], 1'h1);
    par = 6'h00;
    cyc(5);
    chk_bit(gate[0], 1'h0);
    // reset in mid-run with every gate on
    par = 6'h3F;
    cyc(5);
    srst = 1'h1;
    cyc(2);
    chk_vec(16'(gate), 16'h0000);
    srst = 1'h0;
    cyc(6);
    chk_vec(16'(gate), 16'h003F);
    conclude();
  end
endmodule
